// *** cie_irq_arb.sv ***
// Interrupt enable, interrupt flags and arbitration loss capture with an APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cie_irq_arb (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cie_pkg::ADDR_W-1:0] paddr,
  input wire logic [cie_pkg::DATA_W-1:0] pwdata,
  output logic [cie_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event strobes from the protocol core
  input wire logic bus_fault_evt,
  input wire logic arb_loss_evt,
  input wire logic [cie_pkg::POS_W-1:0] frame_bit_pos,
  input wire logic wake_evt,
  input wire logic sleep_set_try,
  input wire logic bus_activity,
  // Status levels watched for changes
  input wire logic passive_state,
  input wire logic overrun_status,
  input wire logic error_status,
  input wire logic bus_status,
  input wire logic tx_buf_free,
  // Receive FIFO
  input wire logic rx_not_empty,
  input wire logic release_rx_cmd,
  // Interrupt to the host
  output logic irq_n
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0] irq_enable_reg;
    logic [7:0] flags;
    logic [cie_pkg::POS_W-1:0] arb_loss_position_reg;
    logic armed;
    logic prev_passive;
    logic prev_overrun;
    logic prev_error;
    logic prev_bus;
    logic prev_tx_free;
    logic pready;
    logic pslverr;
    logic [cie_pkg::DATA_W-1:0] prdata;
    logic irq_n;
  } cie_state_t;

  cie_state_t st_q;
  cie_state_t st_d;

  logic [cie_pkg::IDX_W-1:0] idx;
  logic mapped;
  logic access;
  logic done;
  logic ier_write;
  logic flags_read;
  logic pos_read;
  logic capture;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic [7:0] ier_next;

  // Address decode and transfer phases
  assign idx = paddr[cie_pkg::ADDR_W-1:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  ((idx == cie_pkg::IDX_IRQ_FLAGS) ||
                   (idx == cie_pkg::IDX_IRQ_ENABLE) ||
                   (idx == cie_pkg::IDX_ARB_LOSS_POS));
  assign access = psel && penable && !st_q.pready;
  assign done = psel && penable && st_q.pready && !st_q.pslverr;
  assign ier_write = done && pwrite && (idx == cie_pkg::IDX_IRQ_ENABLE);
  assign flags_read = done && !pwrite && (idx == cie_pkg::IDX_IRQ_FLAGS);
  assign pos_read = done && !pwrite && (idx == cie_pkg::IDX_ARB_LOSS_POS);
  assign capture = arb_loss_evt && st_q.armed;

  // Enable value after any write in this cycle
  // stored enable bits
  assign ier_next = ier_write ? pwdata[7:0] : st_q.irq_enable_reg;

  // Flag set requests, each gated by its enable bit
  always_comb begin
    set_mask = 8'h00;
    set_mask[cie_pkg::BIT_BUS_FAULT] = bus_fault_evt &&
                                       st_q.irq_enable_reg[cie_pkg::BIT_BUS_FAULT];
    set_mask[cie_pkg::BIT_ARB_LOSS] = capture &&
                                      st_q.irq_enable_reg[cie_pkg::BIT_ARB_LOSS];
    set_mask[cie_pkg::BIT_PASSIVE] = (passive_state != st_q.prev_passive) &&
                                     st_q.irq_enable_reg[cie_pkg::BIT_PASSIVE];
    set_mask[cie_pkg::BIT_WAKE] = (wake_evt ||
                                   (sleep_set_try && (bus_activity || (|st_q.flags)))) &&
                                  st_q.irq_enable_reg[cie_pkg::BIT_WAKE];
    set_mask[cie_pkg::BIT_OVERRUN] = overrun_status && !st_q.prev_overrun &&
                                     st_q.irq_enable_reg[cie_pkg::BIT_OVERRUN];
    set_mask[cie_pkg::BIT_WARNING] = ((error_status != st_q.prev_error) ||
                                      (bus_status != st_q.prev_bus)) &&
                                     st_q.irq_enable_reg[cie_pkg::BIT_WARNING];
    set_mask[cie_pkg::BIT_TX_DONE] = tx_buf_free && !st_q.prev_tx_free &&
                                     st_q.irq_enable_reg[cie_pkg::BIT_TX_DONE];
  end

  // Read clears only what the host actually saw, so a late set survives
  // read clears arbitration flag
  assign clr_mask = flags_read ? (st_q.prdata[7:0] & cie_pkg::READ_CLEARABLE) : 8'h00;

  // Next state
  always_comb begin
    st_d = st_q;
    // APB answer one cycle into the access phase
    st_d.pready = access;
    st_d.pslverr = access && !mapped;
    st_d.prdata = cie_pkg::RDATA_IDLE;
    if (access && !pwrite && mapped) begin
      unique case (idx)
        cie_pkg::IDX_IRQ_FLAGS: st_d.prdata[7:0] = st_q.flags;
        cie_pkg::IDX_IRQ_ENABLE: st_d.prdata[7:0] = st_q.irq_enable_reg;
        default: st_d.prdata[cie_pkg::POS_W-1:0] = st_q.arb_loss_position_reg;
      endcase
    end
    st_d.irq_enable_reg = ier_next;
    // Set wins over clear for hardware events
    st_d.flags[7:1] = (st_q.flags[7:1] & ~clr_mask[7:1]) | set_mask[7:1];
    st_d.flags[cie_pkg::BIT_RX] = rx_not_empty && !release_rx_cmd &&
                                  ier_next[cie_pkg::BIT_RX];
    if (capture) begin
      st_d.arb_loss_position_reg = frame_bit_pos;
      st_d.armed = 1'b0;
    end else if (pos_read) begin
      st_d.armed = 1'b1;
    end
    st_d.prev_passive = passive_state;
    st_d.prev_overrun = overrun_status;
    st_d.prev_error = error_status;
    st_d.prev_bus = bus_status;
    st_d.prev_tx_free = tx_buf_free;
    st_d.irq_n = !(|st_d.flags);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q.irq_enable_reg <= cie_pkg::IRQ_ENABLE_RESET;
      st_q.flags <= cie_pkg::IRQ_FLAGS_RESET;
      st_q.arb_loss_position_reg <= cie_pkg::ARB_POS_RESET;
      st_q.armed <= 1'b1;
      st_q.prev_passive <= 1'b0;
      st_q.prev_overrun <= 1'b0;
      st_q.prev_error <= 1'b0;
      st_q.prev_bus <= 1'b0;
      st_q.prev_tx_free <= 1'b0;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.prdata <= cie_pkg::RDATA_IDLE;
      st_q.irq_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq_n = st_q.irq_n;

  // Checks on the behaviour above
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ier_write_s;
    ier_write;
  endsequence

  sequence loss_captured_s;
    arb_loss_evt && st_q.armed;
  endsequence

  sequence release_s;
    release_rx_cmd ##1 rx_not_empty && !release_rx_cmd && st_q.irq_enable_reg[cie_pkg::BIT_RX];
  endsequence

  sequence overrun_rise_s;
    !overrun_status ##1 (overrun_status && st_q.irq_enable_reg[cie_pkg::BIT_OVERRUN]);
  endsequence

  sequence arb_flag_read_s;
    flags_read && st_q.prdata[cie_pkg::BIT_ARB_LOSS] && !capture;
  endsequence

  rx_read_keep_a: assert property (
    (flags_read && rx_not_empty && !release_rx_cmd && ier_next[cie_pkg::BIT_RX])
    |=> st_q.flags[cie_pkg::BIT_RX])
    else $error("receive flag lost on flag read");

  rx_release_a: assert property (
    release_s |-> !st_q.flags[cie_pkg::BIT_RX] ##1 st_q.flags[cie_pkg::BIT_RX])
    else $error("receive flag not cleared then restored on release");

  ier_rw_a: assert property (
    ier_write_s |=> (st_q.irq_enable_reg == $past(pwdata[7:0])))
    else $error("enable register did not store write data");

  bus_fault_a: assert property (
    (!st_q.irq_enable_reg[cie_pkg::BIT_BUS_FAULT] && !st_q.flags[cie_pkg::BIT_BUS_FAULT])
    |=> !st_q.flags[cie_pkg::BIT_BUS_FAULT])
    else $error("bus fault flag set while disabled");

  rie_clear_a: assert property (
    (ier_write && !pwdata[cie_pkg::BIT_RX] && (st_q.flags[7:1] == 7'h00) &&
     (set_mask == 8'h00)) |=> (irq_n && !st_q.flags[cie_pkg::BIT_RX]))
    else $error("interrupt stayed low after receive enable cleared");

  arb_capture_a: assert property (
    loss_captured_s |=> (st_q.arb_loss_position_reg == $past(frame_bit_pos)) && !st_q.armed)
    else $error("arbitration position not captured");

  pos_hold_a: assert property (
    (!st_q.armed && !pos_read) |=> ($stable(st_q.arb_loss_position_reg) && !st_q.armed))
    else $error("arbitration position changed before read");

  pos_rsvd_a: assert property (
    (access && !pwrite && (idx == cie_pkg::IDX_ARB_LOSS_POS) && mapped)
    |=> (prdata[cie_pkg::DATA_W-1:cie_pkg::POS_W] == 27'h0000000) && pready)
    else $error("reserved position bits not zero");

  loss_block_a: assert property (
    !st_q.armed |=> !$rose(st_q.flags[cie_pkg::BIT_ARB_LOSS]))
    else $error("arbitration flag raised before position read");

  flag_read_a: assert property (
    flags_read |=> ((st_q.flags[7:1] & $past(st_q.prdata[7:1]) & ~$past(set_mask[7:1]))
                    == 7'h00))
    else $error("flag read did not clear read flags");

  irq_level_a: assert property (
    irq_n == !(|st_q.flags))
    else $error("interrupt output disagrees with flags");

  wake_try_a: assert property (
    (sleep_set_try && bus_activity && st_q.irq_enable_reg[cie_pkg::BIT_WAKE])
    |=> st_q.flags[cie_pkg::BIT_WAKE])
    else $error("sleep attempt while busy did not raise wake flag");

  arb_gate_a: assert property (
    (!st_q.irq_enable_reg[cie_pkg::BIT_ARB_LOSS] && !st_q.flags[cie_pkg::BIT_ARB_LOSS])
    |=> !st_q.flags[cie_pkg::BIT_ARB_LOSS])
    else $error("arbitration flag set while disabled");

  passive_chg_a: assert property (
    ($changed(passive_state) && st_q.irq_enable_reg[cie_pkg::BIT_PASSIVE])
    |=> st_q.flags[cie_pkg::BIT_PASSIVE])
    else $error("passive state change not flagged");

  wake_evt_a: assert property (
    (wake_evt && st_q.irq_enable_reg[cie_pkg::BIT_WAKE])
    |=> st_q.flags[cie_pkg::BIT_WAKE])
    else $error("wake event not flagged");

  overrun_rise_a: assert property (
    overrun_rise_s |=> st_q.flags[cie_pkg::BIT_OVERRUN])
    else $error("overrun rise not flagged");

  warn_chg_a: assert property (
    (($changed(error_status) || $changed(bus_status)) &&
     st_q.irq_enable_reg[cie_pkg::BIT_WARNING]) |=> st_q.flags[cie_pkg::BIT_WARNING])
    else $error("status change not flagged");

  tx_free_a: assert property (
    ($rose(tx_buf_free) && st_q.irq_enable_reg[cie_pkg::BIT_TX_DONE])
    |=> st_q.flags[cie_pkg::BIT_TX_DONE])
    else $error("transmit buffer release not flagged");

  rx_gate_a: assert property (
    (!st_q.irq_enable_reg[cie_pkg::BIT_RX] && !ier_write)
    |=> !st_q.flags[cie_pkg::BIT_RX])
    else $error("receive flag set while disabled");

  arb_flag_a: assert property (
    (arb_loss_evt && st_q.armed && st_q.irq_enable_reg[cie_pkg::BIT_ARB_LOSS])
    |=> st_q.flags[cie_pkg::BIT_ARB_LOSS])
    else $error("arbitration loss not flagged");

  arb_read_clr_a: assert property (
    arb_flag_read_s |=> !st_q.flags[cie_pkg::BIT_ARB_LOSS])
    else $error("arbitration flag survived flag read");

  pos_nowrite_a: assert property (
    (done && pwrite && (idx == cie_pkg::IDX_ARB_LOSS_POS) && !capture)
    |=> $stable(st_q.arb_loss_position_reg))
    else $error("position register changed by a write");

  irq_low_a: assert property (
    (|st_q.flags) |-> !irq_n)
    else $error("interrupt output high while a flag is pending");

  wake_pend_a: assert property (
    (sleep_set_try && (|st_q.flags) && st_q.irq_enable_reg[cie_pkg::BIT_WAKE])
    |=> st_q.flags[cie_pkg::BIT_WAKE])
    else $error("sleep attempt with pending flag did not raise wake flag");

endmodule

`default_nettype wire

// *** cie_pkg.sv ***
// Register map, bit layout and reset values for the CAN interrupt enable and arbitration block
package cie_pkg;

  // APB address and data widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = ADDR_W - 2;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 10'h003;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h004;
  localparam logic [IDX_W-1:0] IDX_ARB_LOSS_POS = 10'h00B;

  // Bit positions shared by the enable and the flag register
  localparam int BIT_BUS_FAULT = 7;
  localparam int BIT_ARB_LOSS = 6;
  localparam int BIT_PASSIVE = 5;
  localparam int BIT_WAKE = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_WARNING = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX = 0;

  // Arbitration loss position field
  localparam int POS_W = 5;
  localparam int LOST_POSITION_MSB = 4;
  localparam int LOST_POSITION_LSB = 0;

  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
  localparam logic [POS_W-1:0] ARB_POS_RESET = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // Mask of flags that a flag register read clears
  localparam logic [7:0] READ_CLEARABLE = 8'hFE;

endpackage

// *** cie_host_model.sv ***
// Host processor model that drives the APB port of the interrupt block
`timescale 1ns/1ps
`default_nettype none

module cie_host_model (
  // Clock
  input wire logic clk_sys,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Set when a transfer never got its answer
  output logic hung
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // One transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    hung <= (n >= 64);
    // Released lines show the inverse so stale values cannot pass
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

`default_nettype wire

// *** cie_irq_arb_tb_top.sv ***
// Self-checking bench for the interrupt enable and arbitration capture block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module cie_irq_arb_tb_top;
  localparam logic [11:0] A_FLG = {cie_pkg::IDX_IRQ_FLAGS, 2'b00};
  localparam logic [11:0] A_ENA = {cie_pkg::IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] A_POS = {cie_pkg::IDX_ARB_LOSS_POS, 2'b00};
  localparam int BITS [9] = '{7, 6, 5, 4, 3, 2, 2, 1, 4};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq_n, hung, er, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] b;
  logic [4:0] frame_bit_pos = 5'h00;
  logic bus_fault_evt = 1'b0, arb_loss_evt = 1'b0, wake_evt = 1'b0, sleep_set_try = 1'b0;
  logic bus_activity = 1'b1, passive_state = 1'b0, overrun_status = 1'b0;
  logic error_status = 1'b0, bus_status = 1'b0, tx_buf_free = 1'b0;
  logic rx_not_empty = 1'b0, release_rx_cmd = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  cie_irq_arb u_cie_irq_arb (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_fault_evt, .arb_loss_evt, .frame_bit_pos, .wake_evt,
    .sleep_set_try, .bus_activity, .passive_state, .overrun_status, .error_status,
    .bus_status, .tx_buf_free, .rx_not_empty, .release_rx_cmd, .irq_n);

  cie_host_model u_host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hung);

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung transfer ends the run
  always @(posedge clk_sys) begin
    if (hung === 1'b1) begin
      n_mismatch++;
      $display("[ERR] apb pready exp 1 got 0");
      tally_and_finish();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, {24'h0, d}, rd, er);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd, er);
    `CHK(nm, e, rd)
  endtask

  // Pulse one event source for a cycle or toggle one status level, then let it settle
  task automatic fire(input int s, input logic [4:0] p);
    @(posedge clk_sys);
    case (s)
      0: bus_fault_evt <= 1'b1;
      1: begin
        arb_loss_evt <= 1'b1;
        frame_bit_pos <= p;
      end
      2: passive_state <= ~passive_state;
      3: wake_evt <= 1'b1;
      4: overrun_status <= 1'b1;
      5: error_status <= ~error_status;
      6: bus_status <= ~bus_status;
      7: tx_buf_free <= 1'b1;
      default: sleep_set_try <= 1'b1;
    endcase
    @(posedge clk_sys);
    {bus_fault_evt, arb_loss_evt, wake_evt, sleep_set_try} <= 4'h0;
    {overrun_status, tx_buf_free} <= 2'b00;
    repeat (2) @(posedge clk_sys);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("ena reset", A_ENA, 32'h0);
    rdchk("pos reset", A_POS, 32'h0);
    `CHK("irq_n reset", 1'b1, irq_n)
    wr(A_ENA, 8'hA5);
    rdchk("ena rw", A_ENA, 32'hA5);
    u_host.xfer(1'b0, 12'h040, 32'h0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    for (int s = 0; s < 9; s++) begin
      b = 8'h01 << BITS[s];
      wr(A_ENA, b);
      fire(s, 5'h16);
      `CHK("irq_n low", 1'b0, irq_n)
      rdchk("src flag", A_FLG, {24'h0, b});
      rdchk("flag clr", A_FLG, 32'h0);
      `CHK("irq_n high", 1'b1, irq_n)
      wr(A_ENA, 8'h00);
      fire(s, 5'h09);
      rdchk("src off", A_FLG, 32'h0);
      if (s == 1)
        rdchk("pos first", A_POS, 32'h16);
    end
    // Arbitration capture, hold and re-arm
    wr(A_ENA, 8'h40);
    fire(1, 5'h1F);
    rdchk("arb flag", A_FLG, 32'h40);
    fire(1, 5'h0A);
    rdchk("no refire", A_FLG, 32'h0);
    wr(A_POS, 8'hE0);
    rdchk("pos held", A_POS, 32'h1F);
    fire(1, 5'h0A);
    rdchk("pos rearm", A_POS, 32'h0A);
    rdchk("arb again", A_FLG, 32'h40);
    // Sleep attempt with a pending flag and an idle bus
    bus_activity <= 1'b0;
    wr(A_ENA, 8'h90);
    fire(0, 5'h00);
    fire(8, 5'h00);
    rdchk("sleep wake", A_FLG, 32'h90);
    // Receive flag follows the buffer
    wr(A_ENA, 8'h01);
    rx_not_empty <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("rx irq", 1'b0, irq_n)
    rdchk("rx flag", A_FLG, 32'h1);
    rdchk("rx kept", A_FLG, 32'h1);
    @(posedge clk_sys) release_rx_cmd <= 1'b1;
    @(posedge clk_sys) release_rx_cmd <= 1'b0;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      seen = seen | irq_n;
    end
    `CHK("rx gap", 1'b1, seen)
    @(posedge clk_sys);
    `CHK("rx back", 1'b0, irq_n)
    @(posedge clk_sys) begin
      release_rx_cmd <= 1'b1;
      rx_not_empty <= 1'b0;
    end
    @(posedge clk_sys) release_rx_cmd <= 1'b0;
    rdchk("rx empty", A_FLG, 32'h0);
    // Receive enable cleared with and without another source
    rx_not_empty <= 1'b1;
    wr(A_ENA, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK("rie off", 1'b1, irq_n)
    wr(A_ENA, 8'h81);
    fire(0, 5'h00);
    wr(A_ENA, 8'h80);
    repeat (2) @(posedge clk_sys);
    `CHK("other pend", 1'b0, irq_n)
    rdchk("fault only", A_FLG, 32'h80);
    tally_and_finish();
  end
endmodule

`default_nettype wire
